// *** sim/epa_board.sv ***
// board circuitry model seen by the port pins
`timescale 1ns/1ps
module epa_board (
    // pad side of the port
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe_o,
    // external drivers on the board
    input  wire logic [7:0] ext_lvl_i,
    input  wire logic [7:0] ext_en_i,
    // resolved pad levels and fault flag
    output logic      [7:0] pin_i,
    output logic            clash_o
);
    // a pad nobody drives falls to the board pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_i[i] = pin_oe_o[i] ? pin_o[i] : (ext_en_i[i] ? ext_lvl_i[i] : 1'b1);
        end
    end
    // port and board driving one pad at once is a fault
    assign clash_o = |(pin_oe_o & ext_en_i);
endmodule // epa_board

// *** sim/test_eight_bit_io_port_a.sv ***
// self-checking bench for the eight-bit port a
`timescale 1ns/1ps
module test_eight_bit_io_port_a;
    import epa_pkg::*;
    logic       sys_clk_i    = 1'b0;
    logic       arst_n_i     = 1'b0;
    logic       ce_i         = 1'b1;
    logic [2:0] addr_i       = 3'h0;
    logic [7:0] wdata_i      = 8'h00;
    logic       wr_i         = 1'b0;
    logic       rd_i         = 1'b0;
    logic [1:0] cmp_result_i = 2'h0;
    logic [7:0] ext_lvl      = 8'hff;
    logic [7:0] ext_en       = 8'h00;
    logic [7:0] rdata_o, pin_i, pin_o, pin_oe_o, analog_sel_o, rv, m;
    logic       cref_en, t0ck, ssel, vdet, clash;
    logic [5:0] s;
    logic [3:0] osc_tab [5] = '{4'h8, 4'h9, 4'h4, 4'h5, 4'h2};
    logic [1:0] pv [5]      = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0};
    logic [4:0] ck          = 5'b01010;
    int         fails       = 0;
    int         num_checks  = 0;
    int         cycles      = 0;

    epa_port dut_u (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .cmp_result_i(cmp_result_i), .analog_sel_o(analog_sel_o),
        .comparator_reference_out_en_o(cref_en), .timer_zero_clock_in_o(t0ck),
        .slave_select_o(ssel), .voltage_detect_trip_in_sel_o(vdet)
    );
    epa_board board_u (
        .pin_o(pin_o), .pin_oe_o(pin_oe_o), .ext_lvl_i(ext_lvl),
        .ext_en_i(ext_en), .pin_i(pin_i), .clash_o(clash)
    );

    // 25 mhz clock
    always #20 sys_clk_i = ~sys_clk_i;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // register writes and reads, strobes one cycle long
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        @(negedge sys_clk_i);
        chk8(what, exp, rdata_o);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask

    // hang ceiling and pad contention watch
    always @(negedge sys_clk_i) begin
        cycles++;
        if (clash !== 1'b0 && arst_n_i) chk8("pad clash", 8'h00, {7'h0, clash});
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end

    // main sequence
    initial begin
        repeat (5) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        waitc(1);
        chk8("analog select", 8'h2f, analog_sel_o);
        chk8("drive enables", 8'h00, pin_oe_o);
        rchk("latch", EPA_OFS_OUT_LATCH, 8'h00);
        rchk("direction", EPA_OFS_DIRECTION, 8'h3f);
        rchk("pin levels", EPA_OFS_PIN_LEVELS, 8'h10);
        rchk("unmapped", 3'h7, 8'h00);
        wr(EPA_OFS_CONV_CTRL, 8'hff);
        rchk("converter", EPA_OFS_CONV_CTRL, 8'h3f);
        @(posedge sys_clk_i);
        cmp_result_i <= 2'h2;
        wr(EPA_OFS_CMP_CTRL, 8'hff);
        rchk("comparator", EPA_OFS_CMP_CTRL, 8'hbf);
        // all pins digital outputs
        wr(EPA_OFS_OSC_CONFIG, {4'h0, EPA_OSC_INT_IO});
        wr(EPA_OFS_DIRECTION, 8'h00);
        wr(EPA_OFS_PIN_LEVELS, 8'ha5);
        waitc(2);
        chk8("pin out", 8'ha5, pin_o);
        chk8("drive enables", 8'hff, pin_oe_o);
        rchk("latch", EPA_OFS_OUT_LATCH, 8'ha5);
        rchk("pin levels", EPA_OFS_PIN_LEVELS, 8'ha5);
        // all pins inputs driven by the board
        wr(EPA_OFS_DIRECTION, 8'hff);
        waitc(2);
        chk8("drive enables", 8'h00, pin_oe_o);
        ext_en  = 8'hff;
        ext_lvl = 8'h3c;
        waitc(3);
        rchk("pin levels", EPA_OFS_PIN_LEVELS, 8'h3c);
        rchk("latch", EPA_OFS_OUT_LATCH, 8'ha5);
        chk8("timer clock", 8'h01, {7'h0, t0ck});
        chk8("slave select", 8'h01, {7'h0, ssel});
        @(posedge sys_clk_i);
        ext_lvl <= 8'hc3;
        rchk("pin levels", EPA_OFS_PIN_LEVELS, 8'h3c);
        waitc(2);
        rchk("pin levels", EPA_OFS_PIN_LEVELS, 8'hc3);
        chk8("timer clock", 8'h00, {7'h0, t0ck});
        chk8("slave select", 8'h00, {7'h0, ssel});
        // strobes ignored while the clock enable is low
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        wr(EPA_OFS_OUT_LATCH, 8'h00);
        ce_i <= 1'b1;
        rchk("latch", EPA_OFS_OUT_LATCH, 8'ha5);
        // converter channel selection walk
        for (int p = 10; p < 16; p++) begin
            m = {2'b00, p < 11, 1'b0, p < 12, p < 13, p < 14, p < 15};
            wr(EPA_OFS_CONV_CTRL, 8'(p));
            waitc(3);
            chk8("analog select", m, analog_sel_o);
            chk8("trip select", {7'h0, m[5]}, {7'h0, vdet});
            rchk("pin levels", EPA_OFS_PIN_LEVELS, 8'hc3 & ~m);
        end
        // reference output owns pin 0
        ext_en = 8'h00;
        wr(EPA_OFS_CREF_CTRL, 8'hc0);
        wr(EPA_OFS_DIRECTION, 8'hfe);
        waitc(3);
        chk8("reference out", 8'h01, {7'h0, cref_en});
        chk8("drive enables", 8'h00, pin_oe_o);
        rchk("pin levels", EPA_OFS_PIN_LEVELS, 8'hfe);
        wr(EPA_OFS_CREF_CTRL, 8'h80);
        waitc(2);
        chk8("reference out", 8'h00, {7'h0, cref_en});
        chk8("drive enables", 8'h01, pin_oe_o);
        // oscillator modes take pins 6 and 7
        wr(EPA_OFS_DIRECTION, 8'h00);
        wr(EPA_OFS_OUT_LATCH, 8'hff);
        for (int k = 0; k < 5; k++) begin
            wr(EPA_OFS_OSC_CONFIG, {4'h0, osc_tab[k]});
            waitc(2);
            rv = {pv[k], 6'h3f} | {1'b0, ck[k], 6'h00};
            chk8("drive enables", rv, pin_oe_o);
            rchk("latch", EPA_OFS_OUT_LATCH, {pv[k], 6'h3f});
            rchk("direction", EPA_OFS_DIRECTION, 8'h00);
        end
        // divided clock on pin 6
        wr(EPA_OFS_OSC_CONFIG, {4'h0, EPA_OSC_INT_CLKOUT});
        waitc(2);
        for (int t = 0; t < 6; t++) begin
            @(negedge sys_clk_i);
            s[t] = pin_o[6];
        end
        chk8("clock out", {7'h0, ~s[0]}, {7'h0, s[2]});
        chk8("clock out", {7'h0, ~s[1]}, {7'h0, s[3]});
        chk8("clock out", {7'h0, s[0]}, {7'h0, s[4]});
        // second reset in mid-run
        @(posedge sys_clk_i);
        arst_n_i <= 1'b0;
        waitc(2);
        chk8("drive enables", 8'h00, pin_oe_o);
        @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        waitc(1);
        chk8("analog select", 8'h2f, analog_sel_o);
        rchk("direction", EPA_OFS_DIRECTION, 8'h3f);
        stop_test();
    end
endmodule // test_eight_bit_io_port_a

// *** verilog/epa_pkg.sv ***
// constants, register map and helper functions of the eight-bit port a
package epa_pkg;

    // register bus geometry
    localparam int          EPA_ADDR_W         = 3;
    localparam int          EPA_DATA_W         = 8;

    // register offsets
    localparam logic [2:0]  EPA_OFS_PIN_LEVELS = 3'h0;
    localparam logic [2:0]  EPA_OFS_OUT_LATCH  = 3'h1;
    localparam logic [2:0]  EPA_OFS_DIRECTION  = 3'h2;
    localparam logic [2:0]  EPA_OFS_CONV_CTRL  = 3'h3;
    localparam logic [2:0]  EPA_OFS_CMP_CTRL   = 3'h4;
    localparam logic [2:0]  EPA_OFS_CREF_CTRL  = 3'h5;
    localparam logic [2:0]  EPA_OFS_OSC_CONFIG = 3'h6;

    // values after reset
    localparam logic [7:0]  EPA_RST_LATCH      = 8'h00;
    localparam logic [7:0]  EPA_RST_DIRECTION  = 8'hff;
    localparam logic [7:0]  EPA_RST_CONV_CTRL  = 8'h00;
    localparam logic [7:0]  EPA_RST_CMP_CTRL   = 8'h00;
    localparam logic [7:0]  EPA_RST_CREF_CTRL  = 8'h00;
    localparam logic [3:0]  EPA_RST_OSC_CONFIG = 4'h2;
    localparam logic [1:0]  EPA_RST_DIV        = 2'h0;

    // field layouts
    localparam logic [7:0]  EPA_CONV_RD_MASK   = 8'h3f;
    localparam int          EPA_PCFG_LSB       = 0;
    localparam logic [7:0]  EPA_CMP_WR_MASK    = 8'h3f;
    localparam int          EPA_CMP_RESULT_LSB = 6;
    localparam int          EPA_CREF_EN_BIT    = 7;
    localparam int          EPA_CREF_OE_BIT    = 6;

    // pin positions with alternate functions
    localparam int          EPA_PIN_CREF       = 0;
    localparam int          EPA_PIN_T0CK       = 4;
    localparam int          EPA_PIN_SSEL       = 5;
    localparam int          EPA_PIN_OSC_OUT    = 6;
    localparam int          EPA_PIN_OSC_IN     = 7;

    // oscillator select encodings that free pins or put the divided clock on pin 6; all others are crystal
    localparam logic [3:0]  EPA_OSC_INT_IO     = 4'h8;
    localparam logic [3:0]  EPA_OSC_INT_CLKOUT = 4'h9;
    localparam logic [3:0]  EPA_OSC_EXT_IO     = 4'h4;
    localparam logic [3:0]  EPA_OSC_EXT_CLKOUT = 4'h5;

    // clock out runs at the system clock divided by this
    localparam int          EPA_DIVIDED_CLOCK_OUT_DIV       = 4;

    // converter channel count limit: pcfg value that makes every pin digital
    localparam logic [3:0]  EPA_PCFG_ALL_DIG   = 4'hf;

    // analog-selected pins from the converter config field
    function automatic logic [7:0] epa_analog_mask(input logic [3:0] pcfg);
        logic [7:0] m;
        m = 8'h00;
        // channel k is analog while pcfg is below all-digital minus k
        m[0] = (pcfg < EPA_PCFG_ALL_DIG);
        m[1] = (pcfg < EPA_PCFG_ALL_DIG - 4'h1);
        m[2] = (pcfg < EPA_PCFG_ALL_DIG - 4'h2);
        m[3] = (pcfg < EPA_PCFG_ALL_DIG - 4'h3);
        m[5] = (pcfg < EPA_PCFG_ALL_DIG - 4'h4);
        return m;
    endfunction

    // port usability of pins 6 (bit 0) and 7 (bit 1)
    function automatic logic [1:0] epa_osc_port_pins(input logic [3:0] osc);
        logic [1:0] p;
        p = 2'b00;
        if (osc == EPA_OSC_INT_IO) begin
            p = 2'b11;
        end else if (osc == EPA_OSC_INT_CLKOUT) begin
            p = 2'b10;
        end else if (osc == EPA_OSC_EXT_IO) begin
            p = 2'b01;
        end
        return p;
    endfunction

    // true when pin 6 carries the divided clock
    function automatic logic epa_osc_clkout(input logic [3:0] osc);
        return (osc == EPA_OSC_INT_CLKOUT) || (osc == EPA_OSC_EXT_CLKOUT);
    endfunction

endpackage

// *** verilog/epa_port.sv ***
// eight-bit general-purpose port a with alternate-function overrides
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module epa_port
    import epa_pkg::*;
(
    // clock, reset and enable
    input  wire logic                  sys_clk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  ce_i,
    // register port
    input  wire logic [EPA_ADDR_W-1:0] addr_i,
    input  wire logic [EPA_DATA_W-1:0] wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic      [EPA_DATA_W-1:0] rdata_o,
    // pins
    input  wire logic [7:0]            pin_i,
    output logic      [7:0]            pin_o,
    output logic      [7:0]            pin_oe_o,
    // peripheral side
    input  wire logic [1:0]            cmp_result_i,
    output logic      [7:0]            analog_sel_o,
    output logic                       comparator_reference_out_en_o,
    output logic                       timer_zero_clock_in_o,
    output logic                       slave_select_o,
    output logic                       voltage_detect_trip_in_sel_o
);

    // register state
    logic [7:0] latch_reg;
    logic [7:0] latch_next;
    logic [7:0] dir_reg;
    logic [7:0] dir_next;
    logic [7:0] conv_reg;
    logic [7:0] conv_next;
    logic [7:0] cmp_reg;
    logic [7:0] cmp_next;
    logic [7:0] cref_reg;
    logic [7:0] cref_next;
    logic [3:0] osc_reg;
    logic [3:0] osc_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // pin side state
    logic [7:0] pin_reg;
    logic [7:0] pin_next;
    logic [7:0] oe_reg;
    logic [7:0] oe_next;
    logic [1:0] div_reg;
    logic [1:0] div_next;
    logic [7:0] ana_reg;
    logic [7:0] ana_next;
    logic       cref_on_reg;
    logic       cref_on_next;
    logic       t0ck_reg;
    logic       t0ck_next;
    logic       ssel_reg;
    logic       ssel_next;
    logic       hlvd_reg;
    logic       hlvd_next;

    // decoded configuration
    logic [7:0] lvl_sync;
    logic [7:0] ana_mask;
    logic [1:0] osc_port;
    logic       divided_clock_out_mode;
    logic       cref_on;
    logic [7:0] port_mask;
    logic [7:0] level_rd;

    // pin levels pass through two flops before any use
    epa_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .ce_i      (ce_i),
        .async_i   (pin_i),
        .sync_o    (lvl_sync)
    );

    // configuration decode shared by the read path and the pin drivers
    always_comb begin
        ana_mask  = epa_analog_mask(conv_reg[EPA_PCFG_LSB +: 4]);
        osc_port  = epa_osc_port_pins(osc_reg);
        divided_clock_out_mode = epa_osc_clkout(osc_reg);
        cref_on   = cref_reg[EPA_CREF_EN_BIT] & cref_reg[EPA_CREF_OE_BIT];
        port_mask = {osc_port[1], osc_port[0], 6'h3f};
        level_rd  = lvl_sync & ~ana_mask & port_mask;
        level_rd[EPA_PIN_CREF] = level_rd[EPA_PIN_CREF] & ~cref_on;
    end

    // register writes and the one-cycle-late read data
    always_comb begin
        latch_next = latch_reg;
        dir_next   = dir_reg;
        conv_next  = conv_reg;
        cmp_next   = cmp_reg;
        cref_next  = cref_reg;
        osc_next   = osc_reg;
        rdata_next = rdata_reg;
        if (ce_i && wr_i) begin
            if (addr_i == EPA_OFS_PIN_LEVELS) begin
                latch_next = wdata_i;
            end else if (addr_i == EPA_OFS_OUT_LATCH) begin
                latch_next = wdata_i;
            end else if (addr_i == EPA_OFS_DIRECTION) begin
                dir_next = wdata_i;
            end else if (addr_i == EPA_OFS_CONV_CTRL) begin
                conv_next = wdata_i & EPA_CONV_RD_MASK;
            end else if (addr_i == EPA_OFS_CMP_CTRL) begin
                cmp_next = wdata_i & EPA_CMP_WR_MASK;
            end else if (addr_i == EPA_OFS_CREF_CTRL) begin
                cref_next = wdata_i;
            end else if (addr_i == EPA_OFS_OSC_CONFIG) begin
                osc_next = wdata_i[3:0];
            end
        end
        if (ce_i && rd_i) begin
            if (addr_i == EPA_OFS_PIN_LEVELS) begin
                rdata_next = level_rd;
            end else if (addr_i == EPA_OFS_OUT_LATCH) begin
                rdata_next = latch_reg & port_mask;
            end else if (addr_i == EPA_OFS_DIRECTION) begin
                rdata_next = dir_reg & port_mask;
            end else if (addr_i == EPA_OFS_CONV_CTRL) begin
                rdata_next = conv_reg & EPA_CONV_RD_MASK;
            end else if (addr_i == EPA_OFS_CMP_CTRL) begin
                rdata_next = cmp_reg & EPA_CMP_WR_MASK;
                rdata_next[EPA_CMP_RESULT_LSB +: 2] = cmp_result_i;
            end else if (addr_i == EPA_OFS_CREF_CTRL) begin
                rdata_next = cref_reg;
            end else if (addr_i == EPA_OFS_OSC_CONFIG) begin
                rdata_next = {4'h0, osc_reg};
            end else begin
                rdata_next = 8'h00;                                      // unmapped
            end
        end
    end

    // register file
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            latch_reg <= EPA_RST_LATCH;
            dir_reg   <= EPA_RST_DIRECTION;
            conv_reg  <= EPA_RST_CONV_CTRL;
            cmp_reg   <= EPA_RST_CMP_CTRL;
            cref_reg  <= EPA_RST_CREF_CTRL;
            osc_reg   <= EPA_RST_OSC_CONFIG;
            rdata_reg <= 8'h00;
        end else begin
            latch_reg <= latch_next;
            dir_reg   <= dir_next;
            conv_reg  <= conv_next;
            cmp_reg   <= cmp_next;
            cref_reg  <= cref_next;
            osc_reg   <= osc_next;
            rdata_reg <= rdata_next;
        end
    end

    // pin drivers with alternate-function priority over the port
    always_comb begin
        div_next     = ce_i ? div_reg + 2'h1 : div_reg;
        pin_next     = pin_reg;
        oe_next      = oe_reg;
        ana_next     = ana_reg;
        cref_on_next = cref_on_reg;
        t0ck_next    = t0ck_reg;
        ssel_next    = ssel_reg;
        hlvd_next    = hlvd_reg;
        if (ce_i) begin
            pin_next = latch_reg;
            // analog pins still obey their direction bits
            oe_next  = ~dir_reg & port_mask;
            if (cref_on) begin
                oe_next[EPA_PIN_CREF] = 1'b0;
            end
            if (divided_clock_out_mode) begin
                pin_next[EPA_PIN_OSC_OUT] = div_reg[1];
                oe_next[EPA_PIN_OSC_OUT]  = 1'b1;
            end
            ana_next     = ana_mask;
            cref_on_next = cref_on;
            t0ck_next    = lvl_sync[EPA_PIN_T0CK];
            ssel_next    = lvl_sync[EPA_PIN_SSEL];
            hlvd_next    = ana_mask[EPA_PIN_SSEL];
        end
    end

    // pin side registers
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_reg     <= EPA_RST_LATCH;
            oe_reg      <= 8'h00;
            div_reg     <= EPA_RST_DIV;
            ana_reg     <= 8'h00;
            cref_on_reg <= 1'b0;
            t0ck_reg    <= 1'b0;
            ssel_reg    <= 1'b0;
            hlvd_reg    <= 1'b0;
        end else begin
            pin_reg     <= pin_next;
            oe_reg      <= oe_next;
            div_reg     <= div_next;
            ana_reg     <= ana_next;
            cref_on_reg <= cref_on_next;
            t0ck_reg    <= t0ck_next;
            ssel_reg    <= ssel_next;
            hlvd_reg    <= hlvd_next;
        end
    end

    // outputs straight from flops
    assign rdata_o                       = rdata_reg;
    assign pin_o                         = pin_reg;
    assign pin_oe_o                      = oe_reg;
    assign analog_sel_o                  = ana_reg;
    assign comparator_reference_out_en_o = cref_on_reg;
    assign timer_zero_clock_in_o         = t0ck_reg;
    assign slave_select_o                = ssel_reg;
    assign voltage_detect_trip_in_sel_o  = hlvd_reg;

    // checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_clk_run;
        (ce_i && divided_clock_out_mode)[*4];
    endsequence

    sequence s_read_at(logic [2:0] ofs);
        ce_i && rd_i && (addr_i == ofs);
    endsequence

    a_input_hiz: assert property ((ce_i && dir_reg[2]) |=> !pin_oe_o[2])
        else $error("input pin still driven");
    a_output_drive: assert property ((ce_i && !dir_reg[1]) |=>
        (pin_oe_o[1] && pin_o[1] == $past(latch_reg[1])))
        else $error("output pin not driven from latch");
    a_level_write_latch: assert property ((ce_i && wr_i && addr_i == EPA_OFS_PIN_LEVELS)
        |=> latch_reg == $past(wdata_i))
        else $error("pin-level write missed latch");
    a_latch_readback: assert property (s_read_at(EPA_OFS_OUT_LATCH)
        |=> rdata_o[5:0] == $past(latch_reg[5:0]))
        else $error("latch read does not return latch");
    a_osc_pins_zero: assert property ((s_read_at(EPA_OFS_DIRECTION) ##0 !osc_port[0])
        |=> !rdata_o[6])
        else $error("oscillator pin direction bit not zero");
    a_analog_reads_low: assert property ((s_read_at(EPA_OFS_PIN_LEVELS) ##0 ana_mask[1])
        |=> !rdata_o[1])
        else $error("analog pin reads high");
    a_cref_override: assert property ((ce_i && cref_on) |=>
        (!pin_oe_o[0] && comparator_reference_out_en_o))
        else $error("reference output did not take pin 0");
    a_clkout_rate: assert property (s_clk_run |-> pin_o[6] != $past(pin_o[6], 2))
        else $error("clock out not at quarter rate");
    a_crystal_hiz: assert property ((ce_i && osc_port == 2'b00 && !divided_clock_out_mode)
        |=> (!pin_oe_o[6] && !pin_oe_o[7]))
        else $error("oscillator pins driven by port");
    a_timer_clock: assert property (ce_i |=> timer_zero_clock_in_o == $past(lvl_sync[4]))
        else $error("timer clock input not routed");
    // three enabled edges out of reset, so both synchroniser stages hold live pin data
    a_slave_select: assert property ((arst_n_i && ce_i) ##1 ce_i ##1 ce_i |=>
        slave_select_o == $past(pin_i[5], 3))
        else $error("slave select not fed from pin 5");

    // read masks, clock-out drive, trip select and register writes
    a_cref_reads_low: assert property ((s_read_at(EPA_OFS_PIN_LEVELS)
        ##0 cref_on) |=> !rdata_o[0])
        else $error("reference pin reads high");
    a_clkout_drive: assert property ((ce_i && divided_clock_out_mode) |=> pin_oe_o[6])
        else $error("clock out pin not driven");
    a_latch_hi_zero: assert property ((s_read_at(EPA_OFS_OUT_LATCH)
        ##0 !osc_port[1]) |=> !rdata_o[7])
        else $error("oscillator pin latch bit not zero");
    a_level_osc_zero: assert property ((s_read_at(EPA_OFS_PIN_LEVELS)
        ##0 !osc_port[1]) |=> !rdata_o[7])
        else $error("oscillator pin level not zero");
    a_trip_select: assert property ((arst_n_i && ce_i)
        |=> voltage_detect_trip_in_sel_o == $past(ana_mask[EPA_PIN_SSEL]))
        else $error("trip input select not from converter decode");
    a_dir_write: assert property ((ce_i && wr_i && addr_i == EPA_OFS_DIRECTION)
        |=> dir_reg == $past(wdata_i))
        else $error("direction write lost");

endmodule // epa_port

// *** verilog/epa_sync.sv ***
// two-stage synchroniser for the pin levels
`timescale 1ns/1ps
module epa_sync
    import epa_pkg::*;
(
    // clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  ce_i,
    // levels
    input  wire logic [EPA_DATA_W-1:0] async_i,
    output logic      [EPA_DATA_W-1:0] sync_o
);

    logic [EPA_DATA_W-1:0] meta_reg;
    logic [EPA_DATA_W-1:0] meta_next;
    logic [EPA_DATA_W-1:0] sync_reg;
    logic [EPA_DATA_W-1:0] sync_next;

    // first stage feeds only the second
    always_comb begin
        meta_next = ce_i ? async_i : meta_reg;
        sync_next = ce_i ? meta_reg : sync_reg;
    end

    // stage registers
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= 8'h00;
            sync_reg <= 8'h00;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;

endmodule // epa_sync
